/* sim/dtpsc_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module dtpsc_chk
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        spi_cs_n,
    input wire logic        sram_valid,
    input wire logic        trigger_start,
    input wire logic        pattern_start,
    input wire logic        start_delay_insert,
    input wire logic        synth_phase_msb,
    input wire logic [13:0] synth_sine,
    input wire logic [13:0] synth_cosine,
    input wire logic [23:0] synth_freq_word,
    input wire logic [15:0] synth_phase_offset,
    input wire logic [13:0] synth_wave_out,
    input wire logic        addr_counter_step
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence seq_trig_then_pat;
        trigger_start ##1 (!trigger_start && !pattern_start) ##1 (pattern_start && !trigger_start);
    endsequence
    sequence seq_step_pulse;
        $rose(addr_counter_step) ##1 !addr_counter_step;
    endsequence
    sequence seq_quiet;
        (spi_cs_n && !sram_valid) [*4];
    endsequence

    AST_RST_OUT: assert property (
        $fell(rst) |-> synth_freq_word == 24'h000000 && synth_phase_offset == 16'h0000
            && synth_wave_out == 14'h0000 && !start_delay_insert)
        else $error("outputs not cleared by reset");
    AST_WAVE_SEL: assert property (
        !$past(rst) |-> synth_wave_out == $past(synth_sine) || synth_wave_out == $past(synth_cosine))
        else $error("wave output is neither sine nor cosine");
    AST_WAVE_HOLD: assert property (
        spi_cs_n [*3] ##0 ($stable(synth_sine) && $stable(synth_cosine)) |=> $stable(synth_wave_out))
        else $error("wave output moved with steady inputs");
    AST_INSERT_CAUSE: assert property (
        !$past(rst) && $changed(start_delay_insert) |-> $past(pattern_start) || $past(trigger_start))
        else $error("delay flag moved without an event");
    AST_FIRST_INSERT: assert property (
        seq_trig_then_pat |=> start_delay_insert)
        else $error("first pattern after trigger has no delay");
    AST_STEP_PULSE: assert property (
        seq_step_pulse |-> $past(synth_phase_msb) || $past(synth_phase_msb, 2) || $past(synth_phase_msb, 3))
        else $error("counter step pulse without phase msb");
    AST_STEP_IDLE: assert property (
        (spi_cs_n && !synth_phase_msb) [*3] ##0 !addr_counter_step |=> !addr_counter_step)
        else $error("counter step without a phase msb rise");
    AST_CFG_STABLE: assert property (
        seq_quiet |=> $stable(synth_freq_word) && $stable(synth_phase_offset))
        else $error("tuning or phase word moved without a cause");
endmodule // dtpsc_chk

bind dtpsc_top dtpsc_chk i_chk
(
    .clk(clk), .rst(rst), .spi_cs_n(spi_cs_n), .sram_valid(sram_valid),
    .trigger_start(trigger_start), .pattern_start(pattern_start),
    .start_delay_insert(start_delay_insert), .synth_phase_msb(synth_phase_msb),
    .synth_sine(synth_sine), .synth_cosine(synth_cosine), .synth_freq_word(synth_freq_word),
    .synth_phase_offset(synth_phase_offset), .synth_wave_out(synth_wave_out),
    .addr_counter_step(addr_counter_step)
);

`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dtpsc_defs.vh"

module tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        spi_sclk = 1'b0;
    logic        spi_cs_n = 1'b1;
    logic        spi_sdi = 1'b0;
    logic        sram_valid = 1'b0;
    logic        trigger_start = 1'b0;
    logic        pattern_start = 1'b0;
    logic        synth_phase_msb = 1'b0;
    logic [13:0] sram_data = 14'h0000;
    logic [13:0] synth_sine = 14'h0000;
    logic [13:0] synth_cosine = 14'h0000;
    wire         spi_sdo, spi_sdo_oe, start_delay_insert, addr_counter_step;
    wire  [23:0] synth_freq_word;
    wire  [15:0] synth_phase_offset;
    wire  [13:0] synth_wave_out;
    int          fails = 0;
    int          samples_checked = 0;
    int          cnt;
    logic [31:0] rv;
    logic [15:0] hi, lo, ph, x;
    logic [13:0] mw;
    logic [14:0] offs [6] = '{`DTPSC_OFF_TW_HIGH, `DTPSC_OFF_TW_LOW, `DTPSC_OFF_PHASE,
                              `DTPSC_OFF_PAT_CTL1, `DTPSC_OFF_PAT_CTL2, `DTPSC_OFF_TW_MERGE};

    dtpsc_top i_dut
    (
        .clk(clk), .rst(rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe), .sram_data(sram_data), .sram_valid(sram_valid),
        .trigger_start(trigger_start), .pattern_start(pattern_start),
        .start_delay_insert(start_delay_insert), .synth_phase_msb(synth_phase_msb),
        .synth_sine(synth_sine), .synth_cosine(synth_cosine),
        .synth_freq_word(synth_freq_word), .synth_phase_offset(synth_phase_offset),
        .synth_wave_out(synth_wave_out), .addr_counter_step(addr_counter_step)
    );

    always #2 clk = ~clk;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic xfer(input logic [15:0] ins, input logic [15:0] wd, output logic [15:0] rd);
        logic [31:0] sh;
        sh = {ins, wd};
        rd = 16'h0000;
        spi_cs_n = 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            spi_sclk = 1'b0;
            spi_sdi = sh[31-i];
            tick(2);
            if (i > 15)
                rd[31-i] = spi_sdo;
            check(spi_sdo_oe, ins[15] && i > 15);
            spi_sclk = 1'b1;
            tick(2);
        end
        spi_sclk = 1'b0;
        tick(2);
        spi_cs_n = 1'b1;
        tick(3);
    endtask

    task automatic wr(input logic [14:0] a, input logic [15:0] d);
        logic [15:0] y;
        xfer({1'b0, a}, d, y);
    endtask

    task automatic rd(input logic [14:0] a, output logic [15:0] d);
        xfer({1'b1, a}, 16'h0000, d);
    endtask

    task automatic sram_load(input logic [13:0] v);
        sram_data = v;
        sram_valid = 1'b1;
        tick(1);
        sram_valid = 1'b0;
        tick(3);
    endtask

    task automatic pulse(input logic trig);
        trigger_start = trig;
        pattern_start = !trig;
        tick(1);
        trigger_start = 1'b0;
        pattern_start = 1'b0;
        tick(1);
    endtask

    function automatic logic [23:0] exp_tw(logic [23:0] r, logic [13:0] m, int n);
        logic [23:0] top;
        top = r & ~(24'hFFFFFF >> n);
        if (n > 15)
            return r;
        if (n <= 10)
            return top | ({10'h000, m} << (10 - n));
        return top | ({10'h000, m} >> (n - 10));
    endfunction

    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial
    begin
        repeat (50000) @(posedge clk);
        fails++;
        end_of_test();
    end

    initial
    begin
        rv = $urandom(32'h8131);
        tick(3);
        rst = 1'b0;
        tick(1);
        foreach (offs[i])
        begin
            rd(offs[i], x);
            check(x, 16'h0000);
        end
        check(synth_freq_word, 24'h000000);
        foreach (offs[i])
        begin
            rv = $urandom;
            wr(offs[i], rv[15:0]);
            rd(offs[i], x);
            check(x, rv[15:0]);
        end
        rd(15'h0040, x);
        check(x, 16'h0000);
        $display("test registers done");
        rv = $urandom;
        sram_load(rv[13:0]);
        hi = rv[31:16];
        rv = $urandom;
        lo = rv[15:0];
        ph = rv[31:16];
        synth_sine = rv[13:0];
        synth_cosine = ~rv[13:0];
        wr(`DTPSC_OFF_PAT_CTL2, 16'hFFF0);
        wr(`DTPSC_OFF_TW_HIGH, hi);
        wr(`DTPSC_OFF_TW_LOW, lo);
        wr(`DTPSC_OFF_PHASE, ph);
        check(synth_freq_word, {hi, lo[15:8]});
        check(synth_phase_offset, ph);
        check(synth_wave_out, synth_sine);
        check(addr_counter_step, 1'b1);
        wr(`DTPSC_OFF_PAT_CTL2, 16'h0008);
        check(synth_wave_out, synth_cosine);
        $display("test sources done");
        wr(`DTPSC_OFF_PAT_CTL2, 16'h0001);
        for (int n = 0; n < 32; n++)
        begin
            rv = $urandom;
            mw = (n == 0 || n == 15) ? 14'h3FFF : rv[29:16];
            wr(`DTPSC_OFF_TW_MERGE, {rv[15:5], n[4:0]});
            sram_load(mw);
            check(synth_freq_word, exp_tw({hi, lo[15:8]}, mw, n));
        end
        wr(`DTPSC_OFF_PAT_CTL2, 16'h0002);
        sram_load(mw ^ 14'h2AAA);
        check(synth_phase_offset, {mw ^ 14'h2AAA, 2'b00});
        check(synth_freq_word, {hi, lo[15:8]});
        $display("test merge done");
        wr(`DTPSC_OFF_PAT_CTL2, 16'h0004);
        check(addr_counter_step, 1'b0);
        cnt = 0;
        for (int k = 0; k < 24; k++)
        begin
            synth_phase_msb = (k % 8) < 4;
            tick(1);
            cnt += addr_counter_step;
        end
        check(cnt, 3);
        $display("test counter clock done");
        wr(`DTPSC_OFF_PAT_CTL1, 16'h0001);
        pulse(1'b1);
        pulse(1'b0);
        check(start_delay_insert, 1'b1);
        pulse(1'b0);
        check(start_delay_insert, 1'b1);
        wr(`DTPSC_OFF_PAT_CTL1, 16'h0002);
        pulse(1'b1);
        pulse(1'b0);
        check(start_delay_insert, 1'b1);
        pulse(1'b0);
        check(start_delay_insert, 1'b0);
        pulse(1'b0);
        check(start_delay_insert, 1'b0);
        pulse(1'b1);
        pulse(1'b0);
        check(start_delay_insert, 1'b1);
        $display("test start delay done");
        end_of_test();
    end
endmodule // tb_top

`default_nettype wire

/* src/dtpsc_defs.vh */
`ifndef DTPSC_DEFS_VH
`define DTPSC_DEFS_VH

// ----------------------------------------------------------------------------
// register word offsets on the serial port
// ----------------------------------------------------------------------------
`define DTPSC_ADDR_W            15
`define DTPSC_OFF_TW_HIGH       15'h003E
`define DTPSC_OFF_TW_LOW        15'h003F
`define DTPSC_OFF_PHASE         15'h0043
`define DTPSC_OFF_PAT_CTL1      15'h0044
`define DTPSC_OFF_PAT_CTL2      15'h0045
`define DTPSC_OFF_TW_MERGE      15'h0047

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DTPSC_RST_TW_HIGH       16'h0000
`define DTPSC_RST_TW_LOW        16'h0000
`define DTPSC_RST_PHASE         16'h0000
`define DTPSC_RST_PAT_CTL1      16'h0000
`define DTPSC_RST_PAT_CTL2      16'h0000
`define DTPSC_RST_TW_MERGE      16'h0000

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define DTPSC_TW_LOW_MSB        15
`define DTPSC_TW_LOW_LSB        8
`define DTPSC_BIT_FIRST_DLY     1
`define DTPSC_BIT_COS_SEL       3
`define DTPSC_BIT_CNT_CLK_SEL   2
`define DTPSC_BIT_PHASE_MEM     1
`define DTPSC_BIT_TW_MEM        0
`define DTPSC_SHIFT_MSB         4
`define DTPSC_SHIFT_LSB         0

// ----------------------------------------------------------------------------
// merge shift limits and widths
// ----------------------------------------------------------------------------
`define DTPSC_SHIFT_ALIGN       5'h0A
`define DTPSC_SHIFT_MAX         5'h0F
`define DTPSC_TW_W              24
`define DTPSC_SRAM_W            14
`define DTPSC_WAVE_W            14

// ----------------------------------------------------------------------------
// serial frame layout
// ----------------------------------------------------------------------------
`define DTPSC_SPI_INSTR_BITS    5'h10
`define DTPSC_SPI_FRAME_BITS    6'h20
`define DTPSC_SPI_RD_BIT        15

`endif

/* src/dtpsc_spi.v */
`timescale 1ns/1ps
`default_nettype none

`include "dtpsc_defs.vh"

// ----------------------------------------------------------------------------
// serial configuration port: 16-bit instruction then 16-bit data word
// ----------------------------------------------------------------------------
module dtpsc_spi
(
    input  wire                      clk,
    input  wire                      rst,
    input  wire                      spi_sclk,
    input  wire                      spi_cs_n,
    input  wire                      spi_sdi,
    output wire                      spi_sdo,
    output wire                      spi_sdo_oe,
    output wire [`DTPSC_ADDR_W-1:0]  reg_addr,
    output wire                      reg_wr,
    output wire [15:0]               reg_wdata,
    input  wire [15:0]               reg_rdata
);

    reg                      sclk_ff;
    reg  [5:0]               cnt_ff;
    reg  [15:0]              sh_in_ff;
    reg  [15:0]              sh_out_ff;
    reg  [`DTPSC_ADDR_W-1:0] addr_ff;
    reg                      rd_ff;
    reg                      wr_ff;
    reg  [15:0]              wdata_ff;
    reg                      oe_ff;

    wire rise = spi_sclk & ~sclk_ff & ~spi_cs_n;
    wire fall = ~spi_sclk & sclk_ff & ~spi_cs_n;
    wire [15:0] sh_next = {sh_in_ff[14:0], spi_sdi};

    always @(posedge clk)
    begin
        if (rst)
        begin
            sclk_ff   <= 1'b0;
            cnt_ff    <= 6'h00;
            sh_in_ff  <= 16'h0000;
            sh_out_ff <= 16'h0000;
            addr_ff   <= {`DTPSC_ADDR_W{1'b0}};
            rd_ff     <= 1'b0;
            wr_ff     <= 1'b0;
            wdata_ff  <= 16'h0000;
            oe_ff     <= 1'b0;
        end
        else
        begin
            sclk_ff <= spi_sclk;
            wr_ff   <= 1'b0;
            if (spi_cs_n)
            begin
                cnt_ff <= 6'h00;
                oe_ff  <= 1'b0;
            end
            else
            begin
                if (rise && cnt_ff != `DTPSC_SPI_FRAME_BITS)
                begin
                    sh_in_ff <= sh_next;
                    cnt_ff   <= cnt_ff + 6'h01;
                    if (cnt_ff == {1'b0, `DTPSC_SPI_INSTR_BITS} - 6'h01)
                    begin
                        rd_ff   <= sh_next[`DTPSC_SPI_RD_BIT];
                        addr_ff <= sh_next[`DTPSC_ADDR_W-1:0];
                    end
                    if (cnt_ff == `DTPSC_SPI_FRAME_BITS - 6'h01 && !rd_ff)
                    begin
                        wr_ff    <= 1'b1;
                        wdata_ff <= sh_next;
                    end
                end
                // read data is launched on the falling edges after the instruction
                if (fall && cnt_ff == {1'b0, `DTPSC_SPI_INSTR_BITS} && rd_ff)
                begin
                    sh_out_ff <= reg_rdata;
                    oe_ff     <= 1'b1;
                end
                else if (fall && oe_ff)
                begin
                    sh_out_ff <= {sh_out_ff[14:0], 1'b0};
                    if (cnt_ff == `DTPSC_SPI_FRAME_BITS)
                        oe_ff <= 1'b0;
                end
            end
        end
    end

    assign spi_sdo    = sh_out_ff[15];
    assign spi_sdo_oe = oe_ff;
    assign reg_addr   = addr_ff;
    assign reg_wr     = wr_ff;
    assign reg_wdata  = wdata_ff;

endmodule // dtpsc_spi

`default_nettype wire

/* src/dtpsc_top.v */
// Notes on behaviour
// (R1) The upper sixteen tuning word bits sit in a full read-write register reset to zero.
// (R2) The lowest eight tuning word bits come from the upper byte of a second register whose lower byte is reserved, all reset to zero.
// (R3) A sixteen-bit read-write phase offset, reset to zero, feeds the phase offset when register sourcing is chosen.
// (R4) With the first-pattern bit clear the start delay precedes every repetition, with it set only the first pattern after a trigger.
// (R5) With the cosine select bit set the output is the cosine of the accumulated phase instead of the sine.
// (R6) The address counter advances on the converter clock when the select bit is zero and on the phase msb when it is one.
// (R7) With the phase memory bit set the phase offset comes from memory words, otherwise from the phase offset register.
// (R8) With the tuning memory bit clear only the two tuning registers are used, otherwise memory words are merged per the shift field.
// (R9) For shift 0 to 10 the tuning word is the top n register bits, all fourteen memory bits, then 10-n zeros.
// (R10) For shift 11 to 15 the tuning word is the top n register bits then memory bits 13 down to n-10.
// (R11) Reserved bits are stored and read back but steer nothing.
`timescale 1ns/1ps
`default_nettype none

`include "dtpsc_defs.vh"

module dtpsc_top
(
    input  wire                      clk,
    input  wire                      rst,
    // serial configuration port
    input  wire                      spi_sclk,
    input  wire                      spi_cs_n,
    input  wire                      spi_sdi,
    output wire                      spi_sdo,
    output wire                      spi_sdo_oe,
    // pattern memory word and its valid strobe
    input  wire [`DTPSC_SRAM_W-1:0]  sram_data,
    input  wire                      sram_valid,
    // pattern sequencing events
    input  wire                      trigger_start,
    input  wire                      pattern_start,
    output wire                      start_delay_insert,
    // synthesizer feedback
    input  wire                      synth_phase_msb,
    input  wire [`DTPSC_WAVE_W-1:0]  synth_sine,
    input  wire [`DTPSC_WAVE_W-1:0]  synth_cosine,
    // synthesizer controls
    output wire [`DTPSC_TW_W-1:0]    synth_freq_word,
    output wire [15:0]               synth_phase_offset,
    output wire [`DTPSC_WAVE_W-1:0]  synth_wave_out,
    output wire                      addr_counter_step
);

    // ------------------------------------------------------------------------
    // merge of memory word into the tuning word
    // ------------------------------------------------------------------------
    function [`DTPSC_TW_W-1:0] merge_word;
        input [`DTPSC_TW_W-1:0]   regs_word;
        input [`DTPSC_SRAM_W-1:0] mem_word;
        input [4:0]               shift;
        reg   [`DTPSC_TW_W-1:0]   mask;
        reg   [`DTPSC_TW_W-1:0]   mem_ext;
        reg   [`DTPSC_TW_W-1:0]   mem_pos;
        begin
            mask    = ~({`DTPSC_TW_W{1'b1}} >> shift);
            mem_ext = {10'h000, mem_word};
            if (shift <= `DTPSC_SHIFT_ALIGN)
                mem_pos = mem_ext << (`DTPSC_SHIFT_ALIGN - shift);          // [R9]
            else
                mem_pos = mem_ext >> (shift - `DTPSC_SHIFT_ALIGN);          // [R10]
            if (shift > `DTPSC_SHIFT_MAX)
                merge_word = regs_word;
            else
                merge_word = (regs_word & mask) | (mem_pos & ~mask);       // [R9] [R10]
        end
    endfunction

    // ------------------------------------------------------------------------
    // register write path
    // ------------------------------------------------------------------------
    wire [`DTPSC_ADDR_W-1:0] reg_addr;
    wire                     reg_wr;
    wire [15:0]              reg_wdata;
    reg  [15:0]              reg_rdata;

    dtpsc_spi u_spi
    (
        .clk        (clk),
        .rst        (rst),
        .spi_sclk   (spi_sclk),
        .spi_cs_n   (spi_cs_n),
        .spi_sdi    (spi_sdi),
        .spi_sdo    (spi_sdo),
        .spi_sdo_oe (spi_sdo_oe),
        .reg_addr   (reg_addr),
        .reg_wr     (reg_wr),
        .reg_wdata  (reg_wdata),
        .reg_rdata  (reg_rdata)
    );

    reg  [15:0] tuning_word_high_ff;
    reg  [15:0] tuning_word_low_ff;
    reg  [15:0] phase_offset_ff;
    reg  [15:0] pattern_control_one_ff;
    reg  [15:0] pattern_control_two_ff;
    reg  [15:0] tuning_memory_merge_ff;

    always @(posedge clk)
    begin
        if (rst)
        begin
            tuning_word_high_ff    <= `DTPSC_RST_TW_HIGH;                  // [R1]
            tuning_word_low_ff     <= `DTPSC_RST_TW_LOW;                   // [R2]
            phase_offset_ff        <= `DTPSC_RST_PHASE;                    // [R3]
            pattern_control_one_ff <= `DTPSC_RST_PAT_CTL1;
            pattern_control_two_ff <= `DTPSC_RST_PAT_CTL2;
            tuning_memory_merge_ff <= `DTPSC_RST_TW_MERGE;
        end
        else if (reg_wr)
        begin
            // full words are stored, reserved bits included
            case (reg_addr)
                `DTPSC_OFF_TW_HIGH:  tuning_word_high_ff    <= reg_wdata;  // [R1]
                `DTPSC_OFF_TW_LOW:   tuning_word_low_ff     <= reg_wdata;  // [R2] [R11]
                `DTPSC_OFF_PHASE:    phase_offset_ff        <= reg_wdata;  // [R3]
                `DTPSC_OFF_PAT_CTL1: pattern_control_one_ff <= reg_wdata;  // [R11]
                `DTPSC_OFF_PAT_CTL2: pattern_control_two_ff <= reg_wdata;  // [R11]
                `DTPSC_OFF_TW_MERGE: tuning_memory_merge_ff <= reg_wdata;  // [R11]
                default:
                begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // register read path
    // ------------------------------------------------------------------------
    always @*
    begin
        case (reg_addr)
            `DTPSC_OFF_TW_HIGH:  reg_rdata = tuning_word_high_ff;
            `DTPSC_OFF_TW_LOW:   reg_rdata = tuning_word_low_ff;          // [R11]
            `DTPSC_OFF_PHASE:    reg_rdata = phase_offset_ff;
            `DTPSC_OFF_PAT_CTL1: reg_rdata = pattern_control_one_ff;
            `DTPSC_OFF_PAT_CTL2: reg_rdata = pattern_control_two_ff;
            `DTPSC_OFF_TW_MERGE: reg_rdata = tuning_memory_merge_ff;
            default:             reg_rdata = 16'h0000;
        endcase
    end

    // ------------------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------------------
    wire [7:0]  freq_word_lower;
    wire [15:0] freq_word_upper;
    wire [`DTPSC_TW_W-1:0] freq_word_regs;
    wire        first_pattern_delay_only;
    wire        cosine_select;
    wire        addr_counter_clock_select;
    wire        phase_from_sram;
    wire        freq_word_from_sram;
    wire [4:0]  sram_merge_shift;

    assign freq_word_upper  = tuning_word_high_ff;                          // [R1]
    assign freq_word_lower  =
        tuning_word_low_ff[`DTPSC_TW_LOW_MSB:`DTPSC_TW_LOW_LSB];           // [R2]
    assign freq_word_regs   = {freq_word_upper, freq_word_lower};
    assign first_pattern_delay_only  = pattern_control_one_ff[`DTPSC_BIT_FIRST_DLY];
    assign cosine_select             = pattern_control_two_ff[`DTPSC_BIT_COS_SEL];
    assign addr_counter_clock_select = pattern_control_two_ff[`DTPSC_BIT_CNT_CLK_SEL];
    assign phase_from_sram           = pattern_control_two_ff[`DTPSC_BIT_PHASE_MEM];
    assign freq_word_from_sram       = pattern_control_two_ff[`DTPSC_BIT_TW_MEM];
    assign sram_merge_shift  =
        tuning_memory_merge_ff[`DTPSC_SHIFT_MSB:`DTPSC_SHIFT_LSB];

    // ------------------------------------------------------------------------
    // memory word holding
    // ------------------------------------------------------------------------
    reg  [`DTPSC_SRAM_W-1:0] sram_word_ff;

    always @(posedge clk)
    begin
        if (rst)
            sram_word_ff <= {`DTPSC_SRAM_W{1'b0}};
        else if (sram_valid)
            sram_word_ff <= sram_data;
    end

    // ------------------------------------------------------------------------
    // tuning word and phase offset sources
    // ------------------------------------------------------------------------
    reg  [`DTPSC_TW_W-1:0] synth_freq_word_ff;
    reg  [15:0]            synth_phase_offset_ff;
    reg  [`DTPSC_TW_W-1:0] nxt_synth_freq_word;
    reg  [15:0]            nxt_synth_phase_offset;

    always @*
    begin
        if (freq_word_from_sram)
            nxt_synth_freq_word = merge_word(freq_word_regs, sram_word_ff,
                                             sram_merge_shift);             // [R8]
        else
            nxt_synth_freq_word = freq_word_regs;                           // [R8]
        if (phase_from_sram)
            nxt_synth_phase_offset = {sram_word_ff, 2'b00};                 // [R7]
        else
            nxt_synth_phase_offset = phase_offset_ff;                       // [R7] [R3]
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            synth_freq_word_ff    <= {`DTPSC_TW_W{1'b0}};
            synth_phase_offset_ff <= 16'h0000;
        end
        else
        begin
            synth_freq_word_ff    <= nxt_synth_freq_word;
            synth_phase_offset_ff <= nxt_synth_phase_offset;
        end
    end

    // ------------------------------------------------------------------------
    // sine or cosine output
    // ------------------------------------------------------------------------
    reg  [`DTPSC_WAVE_W-1:0] wave_ff;

    always @(posedge clk)
    begin
        if (rst)
            wave_ff <= {`DTPSC_WAVE_W{1'b0}};
        else if (cosine_select)
            wave_ff <= synth_cosine;                                        // [R5]
        else
            wave_ff <= synth_sine;                                          // [R5]
    end

    // ------------------------------------------------------------------------
    // address counter step source
    // ------------------------------------------------------------------------
    reg  msb_ff;
    reg  step_ff;

    always @(posedge clk)
    begin
        if (rst)
        begin
            msb_ff  <= 1'b0;
            step_ff <= 1'b0;
        end
        else
        begin
            msb_ff <= synth_phase_msb;
            if (addr_counter_clock_select)
                step_ff <= synth_phase_msb & ~msb_ff;                       // [R6]
            else
                step_ff <= 1'b1;                                            // [R6]
        end
    end

    // ------------------------------------------------------------------------
    // start delay repeat state machine
    // ------------------------------------------------------------------------
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_FIRST = 3'b010;
    localparam [2:0] ST_REPT  = 3'b100;

    reg  [2:0] state_ff;
    reg  [2:0] nxt_state;
    reg        delay_ff;
    reg        nxt_delay;

    always @*
    begin
        nxt_state = state_ff;
        nxt_delay = delay_ff;
        case (state_ff)
            ST_IDLE:
            begin
                nxt_delay = 1'b0;
                if (trigger_start)
                    nxt_state = ST_FIRST;
            end
            ST_FIRST:
            begin
                if (pattern_start)
                begin
                    nxt_delay = 1'b1;                                       // [R4]
                    nxt_state = ST_REPT;
                end
            end
            ST_REPT:
            begin
                if (trigger_start)
                    nxt_state = ST_FIRST;
                else if (pattern_start)
                    nxt_delay = ~first_pattern_delay_only;                  // [R4]
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_delay = 1'b0;
            end
        endcase
    end

    always @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
            delay_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            delay_ff <= nxt_delay;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign synth_freq_word    = synth_freq_word_ff;
    assign synth_phase_offset = synth_phase_offset_ff;
    assign synth_wave_out     = wave_ff;
    assign addr_counter_step  = step_ff;
    assign start_delay_insert = delay_ff;

endmodule // dtpsc_top

`default_nettype wire
